//--- verilog/perp_regs.vh
`ifndef PERP_REGS_VH
`define PERP_REGS_VH

// Clock period of CLOCK_I, 50 ns
`define PERP_CLK_NS       32'h0000_0032
// Read access time, 70 ns
`define PERP_T_ACC_NS     32'h0000_0046
// Cycles with the output-drive strobe low: access rounded up, plus one for input sampling
`define PERP_ACC_CYC      ((`PERP_T_ACC_NS + `PERP_CLK_NS - 32'h1) / `PERP_CLK_NS + 32'h1)
// Cycles with the write strobe low
`define PERP_WE_CYC       32'h0000_0003
// Byte load window, 100 us
`define PERP_T_PAGE_NS    32'h0001_86a0
// Longest time, rounded down
`define PERP_PAGE_CYC     (`PERP_T_PAGE_NS / `PERP_CLK_NS)
// Cycles kept in hand before the window closes
`define PERP_PAGE_MARGIN  32'h0000_0008
// Cycles waited after the window before polling
`define PERP_PAGE_GUARD   32'h0000_0014
// Largest page, 128 bytes
`define PERP_PAGE_MAX     8'h80
// Typical programming time, 3 ms
`define PERP_T_WC_NS      32'h002d_c6c0
// Poll limit, ten times the typical programming time in cycles, at the poll counter width
`define PERP_POLL_CYC     20'h927c0

`endif

//--- verilog/perp_tmr.v
`timescale 1ns/1ns
`default_nettype none

module perp_tmr (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_n_i,
   // Control
   input  wire        clr_i,
   // Elapsed cycles
   output reg  [19:0] cnt_o
);

   // Saturates so a long stall never wraps back into an open window
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_o <= 20'h00000;
      end else if (clr_i) begin
         cnt_o <= 20'h00000;
      end else if (cnt_o != 20'hfffff) begin
         cnt_o <= cnt_o + 20'h00001;
      end
   end

endmodule

`default_nettype wire

//--- verilog/perp_ctrl.v
`timescale 1ns/1ns
`default_nettype none
`include "perp_regs.vh"

// Function
// [RULE1] Read only with chip-select and output-drive low
// [RULE2] Read ends when either strobe goes high
// [RULE3] Device floats data while either strobe high
// [RULE4] Chip-select low for every access
// [RULE5] Write: chip-select, write low, output-drive high
// [RULE6] Address taken at later falling edge
// [RULE7] Data taken at earlier rising edge
// [RULE8] Byte write completes on its own
// [RULE9] Up to 128 loads programmed together
// [RULE10] Page bits 14..7 fixed during page
// [RULE11] Any write may grow into a page
// [RULE12] Next write fall within 100 us
// [RULE13] Silence of 100 us starts programming
// [RULE14] Busy read of last byte inverts bit 7
// [RULE15] Done read returns true bit 7
// [RULE16] Bit 6 toggles per read while busy
// [RULE17] Toggling stops when programming ends
// [RULE18] Writes ignored while programming runs
module perp_ctrl #(
   parameter [19:0] POLL_LIMIT = `PERP_POLL_CYC
) (
   // Clock and reset
   input  wire        CLOCK_I,
   input  wire        RST_N_I,
   // User command port
   input  wire        CMD_VALID_I,
   input  wire        CMD_WRITE_I,
   input  wire [14:0] CMD_ADDR_I,
   input  wire [7:0]  CMD_WDATA_I,
   output reg         CMD_READY_O,
   // User status and read data
   output reg  [7:0]  RD_DATA_O,
   output reg         RD_VALID_O,
   output reg         BUSY_O,
   output reg         DONE_O,
   output reg         ERR_O,
   // Memory pins
   output reg  [14:0] WORD_ADDRESS_LINES_O,
   output reg  [7:0]  BYTE_LANE_PINS_O,
   output reg         BYTE_LANE_PINS_OE_O,
   input  wire [7:0]  BYTE_LANE_PINS_I,
   output reg         CHIP_SEL_N_O,
   output reg         OUT_DRV_N_O,
   output reg         WR_STB_N_O
);

   localparam [8:0] S_IDLE = 9'h001;
   localparam [8:0] S_RSET = 9'h002;
   localparam [8:0] S_RSTB = 9'h004;
   localparam [8:0] S_WSET = 9'h008;
   localparam [8:0] S_WSTB = 9'h010;
   localparam [8:0] S_WHLD = 9'h020;
   localparam [8:0] S_PAGE = 9'h040;
   localparam [8:0] S_POLL = 9'h080;
   localparam [8:0] S_EXEC = 9'h100;

   // Full-width forms, cut to the counter widths below
   localparam [31:0] ACC_CYC_W   = `PERP_ACC_CYC;
   localparam [31:0] WE_CYC_W    = `PERP_WE_CYC;
   localparam [31:0] PAGE_OPEN_W = `PERP_PAGE_CYC - `PERP_PAGE_MARGIN;
   localparam [31:0] PAGE_SHUT_W = `PERP_PAGE_CYC + `PERP_PAGE_GUARD;
   localparam [2:0]  ACC_CYC     = ACC_CYC_W[2:0];
   localparam [2:0]  WE_CYC      = WE_CYC_W[2:0];
   localparam [19:0] PAGE_OPEN   = PAGE_OPEN_W[19:0];
   localparam [19:0] PAGE_SHUT   = PAGE_SHUT_W[19:0];

   reg  [8:0]  state_ff;
   reg  [2:0]  stb_ff;
   reg         c_wr_ff;
   reg  [14:0] c_addr_ff;
   reg  [7:0]  c_data_ff;
   reg         pend_ff;
   reg  [7:0]  pg_ff;
   reg  [7:0]  pg_cnt_ff;
   reg         poll_ff;
   reg         first_ff;
   reg         prv_ff;
   wire [19:0] tmr_cnt;
   wire        accept;
   wire        shut;
   wire        tmr_clr;

   function [7:0] perp_page;
      input [14:0] a;
      begin
         perp_page = a[14:7];
      end
   endfunction

   assign accept  = CMD_VALID_I & CMD_READY_O;
   assign shut    = (tmr_cnt >= PAGE_SHUT);
   // Cleared at the write-strobe fall and again when polling begins
   assign tmr_clr = ((state_ff == S_WSTB) && (stb_ff == 3'h0)) ||
                    ((state_ff == S_PAGE) && shut && !accept);

   perp_tmr u_tmr (
      .clk_i   (CLOCK_I),
      .rst_n_i (RST_N_I),
      .clr_i   (tmr_clr),
      .cnt_o   (tmr_cnt)
   );

   always @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_ff             <= S_IDLE;
         stb_ff               <= 3'h0;
         c_wr_ff              <= 1'b0;
         c_addr_ff            <= 15'h0000;
         c_data_ff            <= 8'h00;
         pend_ff              <= 1'b0;
         pg_ff                <= 8'h00;
         pg_cnt_ff            <= 8'h00;
         poll_ff              <= 1'b0;
         first_ff             <= 1'b0;
         prv_ff               <= 1'b0;
         CMD_READY_O          <= 1'b0;
         RD_DATA_O            <= 8'h00;
         RD_VALID_O           <= 1'b0;
         BUSY_O               <= 1'b0;
         DONE_O               <= 1'b0;
         ERR_O                <= 1'b0;
         WORD_ADDRESS_LINES_O <= 15'h0000;
         BYTE_LANE_PINS_O     <= 8'h00;
         BYTE_LANE_PINS_OE_O  <= 1'b0;
         CHIP_SEL_N_O         <= 1'b1;
         OUT_DRV_N_O          <= 1'b1;
         WR_STB_N_O           <= 1'b1;
      end else begin
         RD_VALID_O <= 1'b0;
         DONE_O     <= 1'b0;
         ERR_O      <= 1'b0;
         case (state_ff)
            S_IDLE: begin
               if (accept) begin
                  c_wr_ff     <= CMD_WRITE_I;
                  c_addr_ff   <= CMD_ADDR_I;
                  c_data_ff   <= CMD_WDATA_I;
                  CMD_READY_O <= 1'b0;
                  if (CMD_WRITE_I) begin
                     // First byte of a possible page
                     pg_ff     <= perp_page(CMD_ADDR_I); // [RULE11]
                     pg_cnt_ff <= 8'h00;
                     state_ff  <= S_WSET;
                  end else begin
                     state_ff <= S_RSET;
                  end
               end else begin
                  CMD_READY_O <= 1'b1;
               end
            end
            S_WSET: begin
               // Chip-select falls first, so the write-strobe fall latches the address
               CHIP_SEL_N_O         <= 1'b0; // [RULE4] [RULE6]
               OUT_DRV_N_O          <= 1'b1; // [RULE5]
               WORD_ADDRESS_LINES_O <= c_addr_ff;
               BYTE_LANE_PINS_O     <= c_data_ff;
               BYTE_LANE_PINS_OE_O  <= 1'b1;
               stb_ff               <= 3'h0;
               state_ff             <= S_WSTB;
            end
            S_WSTB: begin
               if (stb_ff == 3'h0) begin
                  WR_STB_N_O <= 1'b0; // [RULE5]
                  stb_ff     <= stb_ff + 3'h1;
               end else if (stb_ff == WE_CYC) begin
                  // Write strobe rises before chip-select, so it latches the data
                  WR_STB_N_O <= 1'b1; // [RULE7]
                  state_ff   <= S_WHLD;
               end else begin
                  stb_ff <= stb_ff + 3'h1;
               end
            end
            S_WHLD: begin
               // Data held one cycle past the rising edge
               CHIP_SEL_N_O        <= 1'b1;
               BYTE_LANE_PINS_OE_O <= 1'b0;
               pg_cnt_ff           <= pg_cnt_ff + 8'h01; // [RULE9]
               BUSY_O              <= 1'b1; // [RULE8]
               CMD_READY_O         <= 1'b1;
               state_ff            <= S_PAGE;
            end
            S_PAGE: begin
               if (accept) begin
                  c_wr_ff     <= CMD_WRITE_I;
                  c_addr_ff   <= CMD_ADDR_I;
                  c_data_ff   <= CMD_WDATA_I;
                  CMD_READY_O <= 1'b0;
                  // Extend only inside the window with room for the strobe lead-in
                  if (CMD_WRITE_I && (perp_page(CMD_ADDR_I) == pg_ff) && // [RULE10]
                      (pg_cnt_ff < `PERP_PAGE_MAX) && (tmr_cnt < PAGE_OPEN)) begin // [RULE12] [RULE9]
                     state_ff <= S_WSET;
                  end else begin
                     // Held until polling ends, by programming over or the poll limit
                     pend_ff <= 1'b1; // [RULE18]
                  end
               end else if (shut) begin
                  // Window closed, device now programming
                  CMD_READY_O <= 1'b0; // [RULE13]
                  first_ff    <= 1'b1;
                  state_ff    <= S_POLL;
               end
            end
            S_POLL: begin
               if (tmr_cnt >= POLL_LIMIT) begin
                  BUSY_O   <= 1'b0;
                  DONE_O   <= 1'b1;
                  ERR_O    <= 1'b1;
                  poll_ff  <= 1'b0;
                  state_ff <= S_EXEC;
               end else begin
                  poll_ff  <= 1'b1;
                  state_ff <= S_RSET;
               end
            end
            S_RSET: begin
               CHIP_SEL_N_O         <= 1'b0; // [RULE4]
               WORD_ADDRESS_LINES_O <= poll_ff ? {pg_ff, 7'h00} : c_addr_ff;
               stb_ff               <= 3'h0;
               state_ff             <= S_RSTB;
            end
            S_RSTB: begin
               if (stb_ff == ACC_CYC) begin
                  // Raising both strobes ends the read and floats the device
                  OUT_DRV_N_O  <= 1'b1; // [RULE2] [RULE3]
                  CHIP_SEL_N_O <= 1'b1;
                  if (!poll_ff) begin
                     RD_DATA_O  <= BYTE_LANE_PINS_I; // [RULE1]
                     RD_VALID_O <= 1'b1;
                     state_ff   <= S_IDLE;
                  end else if (first_ff) begin
                     prv_ff   <= BYTE_LANE_PINS_I[6]; // [RULE16]
                     first_ff <= 1'b0;
                     state_ff <= S_POLL;
                  end else if (BYTE_LANE_PINS_I[6] == prv_ff) begin
                     // Bit 6 steady; bit 7 polling is not used here
                     BUSY_O   <= 1'b0; // [RULE17] [RULE15] [RULE14]
                     DONE_O   <= 1'b1;
                     poll_ff  <= 1'b0;
                     state_ff <= S_EXEC;
                  end else begin
                     prv_ff   <= BYTE_LANE_PINS_I[6]; // [RULE16]
                     state_ff <= S_POLL;
                  end
               end else begin
                  OUT_DRV_N_O <= 1'b0; // [RULE1]
                  stb_ff      <= stb_ff + 3'h1;
               end
            end
            S_EXEC: begin
               if (pend_ff) begin
                  pend_ff <= 1'b0;
                  if (c_wr_ff) begin
                     pg_ff     <= perp_page(c_addr_ff); // [RULE11]
                     pg_cnt_ff <= 8'h00;
                     state_ff  <= S_WSET;
                  end else begin
                     state_ff <= S_RSET;
                  end
               end else begin
                  state_ff <= S_IDLE;
               end
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

//--- tb/perp_chk_checker.sv
`timescale 1ns/1ns
`default_nettype none
module perp_chk (
   // Clock and reset
   input wire logic        CLOCK_I,
   input wire logic        RST_N_I,
   // Memory pins
   input wire logic [14:0] WORD_ADDRESS_LINES_O,
   input wire logic [7:0]  BYTE_LANE_PINS_O,
   input wire logic        BYTE_LANE_PINS_OE_O,
   input wire logic        CHIP_SEL_N_O,
   input wire logic        OUT_DRV_N_O,
   input wire logic        WR_STB_N_O,
   // Status
   input wire logic        RD_VALID_O,
   input wire logic        BUSY_O,
   input wire logic        DONE_O
);
   logic [7:0]  pg_ff;
   logic [11:0] gap_ff;
   // Page of the previous load and cycles since its strobe fell
   always @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pg_ff  <= 8'h00;
         gap_ff <= 12'h000;
      end else if ($fell(WR_STB_N_O)) begin
         pg_ff  <= WORD_ADDRESS_LINES_O[14:7];
         gap_ff <= 12'h000;
      end else if (gap_ff != 12'hfff) begin
         gap_ff <= gap_ff + 12'h001;
      end
   end
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);
   a_read_select: assert property (!OUT_DRV_N_O |-> !CHIP_SEL_N_O && WR_STB_N_O) else $error("read without select");
   a_bus_free: assert property (!OUT_DRV_N_O |-> !BYTE_LANE_PINS_OE_O) else $error("host drives during read");
   a_write_form: assert property (!WR_STB_N_O |-> OUT_DRV_N_O && !CHIP_SEL_N_O && BYTE_LANE_PINS_OE_O)
      else $error("bad write strobe form");
   a_addr_held: assert property (!CHIP_SEL_N_O && $past(!CHIP_SEL_N_O) |-> $stable(WORD_ADDRESS_LINES_O))
      else $error("address moved while selected");
   a_data_held: assert property ($rose(WR_STB_N_O) |-> BYTE_LANE_PINS_OE_O && $stable(BYTE_LANE_PINS_O))
      else $error("write data not held at strobe rise");
   a_we_width: assert property ($fell(WR_STB_N_O) |-> !WR_STB_N_O [*3] ##1 WR_STB_N_O) else $error("write strobe width");
   a_oe_width: assert property ($fell(OUT_DRV_N_O) |-> ##1 !OUT_DRV_N_O [*2] ##[1:2] OUT_DRV_N_O)
      else $error("read strobe width");
   a_read_end: assert property (RD_VALID_O |-> $rose(OUT_DRV_N_O) && $rose(CHIP_SEL_N_O)) else $error("read not ended");
   a_page_same: assert property ($fell(WR_STB_N_O) && BUSY_O |-> WORD_ADDRESS_LINES_O[14:7] == pg_ff)
      else $error("page changed inside load");
   a_load_gap: assert property ($fell(WR_STB_N_O) && BUSY_O |-> gap_ff < 12'h7cf) else $error("load gap too long");
   a_done_ends: assert property (DONE_O |-> !BUSY_O && $past(BUSY_O)) else $error("done without busy end");
   c_page: cover property ($fell(WR_STB_N_O) && BUSY_O);
   c_read: cover property (RD_VALID_O);
   c_done: cover property (DONE_O);
endmodule
bind perp_ctrl perp_chk u_chk (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .WORD_ADDRESS_LINES_O(WORD_ADDRESS_LINES_O),
   .BYTE_LANE_PINS_O(BYTE_LANE_PINS_O), .BYTE_LANE_PINS_OE_O(BYTE_LANE_PINS_OE_O), .CHIP_SEL_N_O(CHIP_SEL_N_O),
   .OUT_DRV_N_O(OUT_DRV_N_O), .WR_STB_N_O(WR_STB_N_O), .RD_VALID_O(RD_VALID_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O));
`default_nettype wire

//--- tb/perp_mem.sv
`timescale 1ns/1ns
`default_nettype none
module perp_mem #(
   parameter int PROG_NS = 2000,
   parameter int SLOW_NS = 400000
) (
   // Pins from the host
   input  wire logic [14:0] addr_i,
   input  wire logic [7:0]  din_i,
   input  wire logic        cs_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   // Stretches programming far past the poll limit
   input  wire logic        slow_i,
   // Pins to the host
   output logic      [7:0]  dout_o,
   output logic             drive_o
);
   logic [7:0]   mem [0:32767];
   logic [7:0]   pbuf [0:127];
   logic [127:0] ld = '0;
   logic [7:0]   pg;
   logic [14:0]  wa;
   logic [14:0]  la;
   logic [7:0]   lv;
   logic [7:0]   rd;
   logic         busy = 1'b0;
   logic         tgl = 1'b0;
   logic         open = 1'b0;
   time          t_fall = 0;
   wire          wsel_n = cs_n_i | we_n_i | ~oe_n_i;
   wire          rsel_n = cs_n_i | oe_n_i;
   initial begin
      for (int i = 0; i < 32768; i++) mem[i] = 8'h00;
   end
   always @(negedge wsel_n) if (!busy) begin
      wa = addr_i;
      if (!open) pg = addr_i[14:7];
      open = 1'b1;
      t_fall = $time;
   end
   always @(posedge wsel_n) if (open && !busy && wa[14:7] == pg) begin
      pbuf[wa[6:0]] = din_i;
      ld[wa[6:0]] = 1'b1;
      la = wa;
      lv = din_i;
   end
   always #50 if (open && $time - t_fall >= 100000) begin
      open = 1'b0;
      busy = 1'b1;
      #(slow_i ? SLOW_NS : PROG_NS);
      for (int i = 0; i < 128; i++) if (ld[i]) mem[{pg, i[6:0]}] = pbuf[i];
      ld = '0;
      busy = 1'b0;
   end
   always @(negedge rsel_n) if (busy) tgl = ~tgl;
   always_comb begin
      rd = mem[addr_i];
      if (busy && addr_i == la) rd[7] = ~lv[7];
      if (busy) rd[6] = tgl;
   end
   // Released bus shows the inverse so a stale value never matches
   assign drive_o = ~rsel_n;
   assign dout_o = drive_o ? rd : ~rd;
endmodule
`default_nettype wire

//--- tb/parallel_eeprom_rw_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
module parallel_eeprom_rw_port_tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        valid = 1'b0;
   logic        write = 1'b0;
   logic [14:0] addr = 15'h0000;
   logic [7:0]  wdata = 8'h00;
   logic        slow = 1'b0;
   wire         ready, rd_valid, busy, done, err, oe, cs_n, od_n, we_n, drv;
   wire  [7:0]  rdata, dq_o, mem_q, dq;
   wire  [14:0] pins_a;
   int          miscompares = 0;
   int          checks = 0;
   assign dq = oe ? dq_o : mem_q;
   always #25 clk = ~clk;
   perp_ctrl #(.POLL_LIMIT(20'h000c8)) dut (.CLOCK_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(valid), .CMD_WRITE_I(write),
      .CMD_ADDR_I(addr), .CMD_WDATA_I(wdata), .CMD_READY_O(ready), .RD_DATA_O(rdata), .RD_VALID_O(rd_valid),
      .BUSY_O(busy), .DONE_O(done), .ERR_O(err), .WORD_ADDRESS_LINES_O(pins_a), .BYTE_LANE_PINS_O(dq_o),
      .BYTE_LANE_PINS_OE_O(oe), .BYTE_LANE_PINS_I(dq), .CHIP_SEL_N_O(cs_n), .OUT_DRV_N_O(od_n), .WR_STB_N_O(we_n));
   perp_mem u_mem (.addr_i(pins_a), .din_i(dq), .cs_n_i(cs_n), .oe_n_i(od_n), .we_n_i(we_n), .slow_i(slow),
      .dout_o(mem_q), .drive_o(drv));
   // Host and memory never drive the byte lanes together
   always @(negedge clk) if (rst_n) chk("lane owners", 8'h00, {7'h00, oe & drv});
   task automatic stop_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmd(input logic w, input logic [14:0] a, input logic [7:0] d);
      @(posedge clk);
      valid <= 1'b1;
      write <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk iff ready === 1'b1);
      valid <= 1'b0;
   endtask
   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      cmd(1'b0, a, 8'h00);
      @(posedge clk iff rd_valid === 1'b1);
      chk("read data", e, rdata);
   endtask
   task automatic wait_done(input logic e_err);
      @(posedge clk iff done === 1'b1);
      chk("error flag", {7'h00, e_err}, {7'h00, err});
   endtask
   task automatic t_byte;
      cmd(1'b1, 15'h0123, 8'ha5);
      wait_done(1'b0);
      rd(15'h0123, 8'ha5);
      $display("test byte ended");
   endtask
   task automatic t_page;
      for (int i = 0; i < 128; i++) cmd(1'b1, {8'h12, i[6:0]}, i[7:0] ^ 8'h3c);
      // A 129th load is held and becomes a page of its own
      cmd(1'b1, 15'h0900, 8'h5a);
      wait_done(1'b0);
      wait_done(1'b0);
      rd(15'h0900, 8'h5a);
      rd(15'h0901, 8'h3d);
      rd(15'h097f, 8'h43);
      $display("test page ended");
   endtask
   task automatic t_pend;
      cmd(1'b1, 15'h0200, 8'h11);
      cmd(1'b1, 15'h0300, 8'h22);
      wait_done(1'b0);
      wait_done(1'b0);
      rd(15'h0200, 8'h11);
      rd(15'h0300, 8'h22);
      $display("test other page ended");
   endtask
   task automatic t_rdpend;
      cmd(1'b1, 15'h0500, 8'h5c);
      rd(15'h0500, 8'h5c);
      $display("test held read ended");
   endtask
   task automatic t_slow;
      slow <= 1'b1;
      cmd(1'b1, 15'h0400, 8'h77);
      wait_done(1'b1);
      $display("test slow ended");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_byte;
      t_page;
      t_pend;
      t_rdpend;
      t_slow;
      stop_test;
   end
   // Whole run needs about 15500 cycles
   initial begin
      #(50 * 50000);
      miscompares++;
      stop_test;
   end
endmodule
`default_nettype wire
